// ---- uiso_cfg.svh ----
// How it works
// - isochronous OUT data gets no handshake and no endpoint interrupt; once per frame
// - two buffers per endpoint; bus writes background, processor reads foreground
// - foreground and background roles swap at every start-of-frame
// - start-of-frame interrupt fires even for a corrupted start-of-frame packet
// - stall, nak and ack status bits read zero; no handshake interrupt
// - unread OUT foreground data is flushed at swap; flush flag held next frame
// - missed or zero-length OUT leaves an empty foreground buffer, no flag
// - OUT packet error leaves buffer empty and sets error flag for next frame
// - OUT overflow clears the buffer and sets error flag at next start-of-frame
// - endpoint clear command empties both buffers
// - IN token sends whole background transmit buffer, no handshake phase
// - transmit buffer is emptied when the swap moves it
// - no fifo-enable command or fifo-ready bit for isochronous IN
// - missed-IN flag set next frame if data was present and no IN completed
// - clear during IN read forces a bit-stuffing error in the packet
// - writes to a full transmit buffer are dropped; accepted bytes still sent
// - no endpoint interrupt from isochronous IN transactions
`ifndef UISO_CFG_SVH
`define UISO_CFG_SVH
`define UISO_DEPTH     64
`define UISO_CW        7
`define UISO_FG_RST    1'h0
`define UISO_PKT_FIFO  4
`endif

// ---- uiso_ep.sv ----
`timescale 1ns/1ps
`include "uiso_cfg.svh"
module uiso_ep import uiso_pkg::*; #(
    parameter int DEPTH = `UISO_DEPTH
) (
    input  wire logic       CLOCK,
    input  wire logic       RESETN,
    input  wire logic       SOF_SEEN,
    input  wire logic       SOF_CORRUPT,
    input  wire logic       EP_IS_IN,
    input  wire logic       EP_CLEAR,
    input  wire logic [7:0] RX_DATA,
    input  wire logic       RX_VALID,
    output logic            RX_READY,
    input  wire logic       RX_END,
    input  wire logic       RX_BAD,
    input  wire logic       IN_TOKEN,
    input  wire logic       IN_DONE_OK,
    output logic [7:0]      TX_DATA,
    output logic            TX_VALID,
    output logic            TX_LAST_BYTE,
    output logic            TX_FORCE_STUFF_ERR,
    input  wire logic       PROC_SEL,
    input  wire logic       PROC_RD,
    input  wire logic       PROC_WR,
    input  wire logic [7:0] PROC_WDATA,
    output logic [7:0]      PROC_RDATA,
    output logic [`UISO_CW-1:0] RX_BYTE_COUNT,
    output logic            ISO_FIFO_EMPTY,
    output logic            TX_FULL,
    output logic            FLAG_FLUSH,
    output logic            FLAG_ISO_ERR,
    output logic            FLAG_MISS_IN,
    output logic            FLAG_STALL,
    output logic            FLAG_NAK,
    output logic            FLAG_ACK,
    output logic            SOF_IRQ,
    output logic            EP_IRQ
);
    localparam int CW = `UISO_CW;
    localparam int AW = $clog2(DEPTH);
    // bus data passes a small elastic buffer; it drains every cycle, bytes the store cannot take are dropped
    uiso_byte_t pf_out;
    logic       pf_ready;
    logic       pf_valid;
    logic [7:0] pf_data;
    uiso_fifo #(.W(8), .D(`UISO_PKT_FIFO)) u_rxq (
        .clk      (CLOCK),
        .rst_n    (RESETN),
        .in_data  (RX_DATA),
        .in_valid (RX_VALID),
        .in_ready (RX_READY),
        .out_data (pf_data),
        .out_valid(pf_valid),
        .out_ready(pf_ready)
    );
    always_comb begin
        pf_out.valid = pf_valid;
        pf_out.data  = pf_data;
    end

    logic [7:0]    buf_q [2][DEPTH];
    logic          fg_q, fg_d;
    logic [CW-1:0] cnt_q [2];
    logic [CW-1:0] cnt_d [2];
    // read pointer is count-wide: a full buffer must be readable to its last byte
    logic [CW-1:0] rp_q, rp_d;
    logic          ovf_q, ovf_d, bad_q, bad_d, sent_q, sent_d;
    logic          flush_q, flush_d, err_q, err_d, miss_q, miss_d;
    logic          sof_q, sof_d;
    uiso_tx_t      tx_q, tx_d;
    logic [AW-1:0] tp_q, tp_d;
    logic          stuff_q, stuff_d;
    logic [7:0]    rdat_q, rdat_d;
    logic          bg;
    logic          rx_take, pw_take;

    always_comb begin
        bg = ~fg_q;
        fg_d = fg_q;
        cnt_d = cnt_q;
        rp_d = rp_q;
        ovf_d = ovf_q;
        bad_d = bad_q;
        sent_d = sent_q;
        flush_d = flush_q;
        err_d = err_q;
        miss_d = miss_q;
        tx_d = tx_q;
        tp_d = tp_q;
        stuff_d = 1'b0;
        rdat_d = rdat_q;
        rx_take = 1'b0;
        pw_take = 1'b0;
        pf_ready = 1'b1;
        sof_d = SOF_SEEN || SOF_CORRUPT;
        // OUT: bus writes only background, overflow drops the whole packet
        if (!EP_IS_IN && pf_out.valid) begin
            if (cnt_q[bg] == CW'(DEPTH)) begin
                ovf_d = 1'b1;
                cnt_d[bg] = '0;
            end else if (!ovf_q) begin
                rx_take = 1'b1;
                cnt_d[bg] = cnt_q[bg] + 1'b1;
            end
        end
        if (!EP_IS_IN && RX_END && RX_BAD) begin
            bad_d = 1'b1;
            cnt_d[bg] = '0;
        end
        // processor side: reads or writes only foreground
        if (PROC_SEL && PROC_RD && !EP_IS_IN && rp_q < cnt_q[fg_q]) begin
            rdat_d = buf_q[fg_q][AW'(rp_q)];
            rp_d = rp_q + 1'b1;
        end
        if (PROC_SEL && PROC_WR && EP_IS_IN && cnt_q[fg_q] != CW'(DEPTH)) begin
            pw_take = 1'b1;
            cnt_d[fg_q] = cnt_q[fg_q] + 1'b1;
        end
        // IN: stream whole background buffer, no handshake
        case (tx_q)
            TX_IDLE: begin
                if (EP_IS_IN && IN_TOKEN && cnt_q[bg] != '0) begin
                    tp_d = '0;
                    tx_d = (cnt_q[bg] == CW'(1)) ? TX_LAST : TX_SEND;
                end
            end
            TX_SEND: begin
                tp_d = tp_q + 1'b1;
                if (CW'(tp_q) + CW'(2) == cnt_q[bg])
                    tx_d = TX_LAST;
            end
            TX_LAST: tx_d = TX_IDLE;
            default: tx_d = TX_IDLE;
        endcase
        if (EP_IS_IN && IN_DONE_OK)
            sent_d = 1'b1;
        if (EP_CLEAR) begin
            cnt_d[0] = '0;
            cnt_d[1] = '0;
            rp_d = '0;
            ovf_d = 1'b0;
            bad_d = 1'b0;
            if (tx_q != TX_IDLE) begin
                stuff_d = 1'b1;
                tx_d = TX_IDLE;
            end
        end
        if (sof_q) begin
            fg_d = ~fg_q;
            // frame flags live exactly one frame
            flush_d = !EP_IS_IN && (rp_q != cnt_q[fg_q]);
            err_d = !EP_IS_IN && (ovf_q || bad_q);
            miss_d = EP_IS_IN && cnt_q[bg] != '0 && !sent_q;
            if (EP_IS_IN) begin
                // only the buffer leaving the bus side is emptied; fresh processor data goes out next frame
                cnt_d[bg] = '0;
            end else begin
                cnt_d[fg_q] = '0;
                if (ovf_q || bad_q)
                    cnt_d[bg] = '0;
            end
            rp_d = '0;
            ovf_d = 1'b0;
            bad_d = 1'b0;
            sent_d = 1'b0;
            tx_d = TX_IDLE;
        end
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            fg_q <= `UISO_FG_RST;
            cnt_q[0] <= '0;
            cnt_q[1] <= '0;
            rp_q <= '0;
            ovf_q <= 1'b0;
            bad_q <= 1'b0;
            sent_q <= 1'b0;
            flush_q <= 1'b0;
            err_q <= 1'b0;
            miss_q <= 1'b0;
            sof_q <= 1'b0;
            tx_q <= TX_IDLE;
            tp_q <= '0;
            stuff_q <= 1'b0;
            rdat_q <= 8'h00;
        end else begin
            fg_q <= fg_d;
            cnt_q <= cnt_d;
            rp_q <= rp_d;
            ovf_q <= ovf_d;
            bad_q <= bad_d;
            sent_q <= sent_d;
            flush_q <= flush_d;
            err_q <= err_d;
            miss_q <= miss_d;
            sof_q <= sof_d;
            tx_q <= tx_d;
            tp_q <= tp_d;
            stuff_q <= stuff_d;
            rdat_q <= rdat_d;
        end
    end

    // storage has no reset; validity is held by the counts
    always_ff @(posedge CLOCK) begin
        if (rx_take)
            buf_q[bg][AW'(cnt_q[bg])] <= pf_out.data;
        if (pw_take)
            buf_q[fg_q][AW'(cnt_q[fg_q])] <= PROC_WDATA;
    end

    // outputs: flops or constant-zero handshake bits
    logic [7:0] txd_q;
    logic       txv_q, txl_q;
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            txd_q <= 8'h00;
            txv_q <= 1'b0;
            txl_q <= 1'b0;
        end else begin
            txd_q <= buf_q[bg][tp_q];
            txv_q <= (tx_q != TX_IDLE) && !EP_CLEAR;
            txl_q <= (tx_q == TX_LAST);
        end
    end
    logic [CW-1:0] rxc_q;
    logic          emp_q, full_q;
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            rxc_q <= '0;
            emp_q <= 1'b1;
            full_q <= 1'b0;
        end else begin
            rxc_q <= cnt_d[fg_d] - rp_d;
            emp_q <= (cnt_d[fg_d] == rp_d);
            full_q <= (cnt_d[fg_d] == CW'(DEPTH));
        end
    end
    assign TX_DATA = txd_q;
    assign TX_VALID = txv_q;
    assign TX_LAST_BYTE = txl_q;
    assign TX_FORCE_STUFF_ERR = stuff_q;
    assign PROC_RDATA = rdat_q;
    assign RX_BYTE_COUNT = rxc_q;
    assign ISO_FIFO_EMPTY = emp_q;
    assign TX_FULL = full_q;
    assign FLAG_FLUSH = flush_q;
    assign FLAG_ISO_ERR = err_q;
    assign FLAG_MISS_IN = miss_q;
    assign FLAG_STALL = 1'b0;
    assign FLAG_NAK = 1'b0;
    assign FLAG_ACK = 1'b0;
    assign SOF_IRQ = sof_q;
    assign EP_IRQ = 1'b0;

    a_sof_irq_follows: assert property (@(posedge CLOCK) disable iff (!RESETN)
        (SOF_SEEN || SOF_CORRUPT) |=> SOF_IRQ) else $error("sof irq missing");
    a_role_swap: assert property (@(posedge CLOCK) disable iff (!RESETN)
        SOF_IRQ |=> (fg_q != $past(fg_q))) else $error("roles not swapped");
    a_no_swap: assert property (@(posedge CLOCK) disable iff (!RESETN)
        !SOF_IRQ |=> (fg_q == $past(fg_q))) else $error("roles swapped off frame");
    a_flush_flag: assert property (@(posedge CLOCK) disable iff (!RESETN)
        (SOF_IRQ && !EP_IS_IN && !ISO_FIFO_EMPTY) |=> FLAG_FLUSH) else $error("flush flag missing");
    a_err_flag: assert property (@(posedge CLOCK) disable iff (!RESETN)
        (SOF_IRQ && !EP_IS_IN && bad_q) |=> FLAG_ISO_ERR) else $error("iso error flag missing");
    a_flag_hold: assert property (@(posedge CLOCK) disable iff (!RESETN)
        (!SOF_IRQ ##1 1'b1) |-> $stable(FLAG_ISO_ERR) && $stable(FLAG_FLUSH)) else $error("flag moved mid frame");
    a_clear_both: assert property (@(posedge CLOCK) disable iff (!RESETN)
        (EP_CLEAR && !SOF_IRQ) |=> (cnt_q[0] == '0 && cnt_q[1] == '0)) else $error("clear left data");
    a_stuff_err: assert property (@(posedge CLOCK) disable iff (!RESETN)
        (EP_CLEAR && tx_q != TX_IDLE) |=> TX_FORCE_STUFF_ERR) else $error("no stuffing error");
    a_handshake_zero: assert property (@(posedge CLOCK) disable iff (!RESETN)
        !(FLAG_STALL || FLAG_NAK || FLAG_ACK || EP_IRQ)) else $error("handshake bit set");
    a_tx_full_drop: assert property (@(posedge CLOCK) disable iff (!RESETN)
        (PROC_WR && cnt_q[fg_q] == CW'(DEPTH) && !SOF_IRQ && !EP_CLEAR) |=> cnt_q[fg_q] == CW'(DEPTH))
        else $error("full buffer grew");
endmodule

// ---- uiso_fifo.sv ----
`timescale 1ns/1ps
module uiso_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wp_q, rp_q, wp_d, rp_d;
    logic [AW:0]   cnt_q, cnt_d;
    logic          wr, rd;
    always_comb begin
        wr = in_valid && in_ready;
        rd = out_valid && out_ready;
        wp_d = wr ? ((wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1) : wp_q;
        rp_d = rd ? ((rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1) : rp_q;
        cnt_d = cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
    end
    always_ff @(posedge clk) begin
        if (wr)
            mem_q[wp_q] <= in_data;
    end
    assign in_ready  = (cnt_q != (AW+1)'(D));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rp_q];
endmodule

// ---- uiso_host.sv ----
`timescale 1ns/1ps
module uiso_host (
    input  wire logic       clk,
    output logic            sof_seen,
    output logic            sof_corrupt,
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    input  wire logic       rx_ready,
    output logic            rx_end,
    output logic            rx_bad,
    output logic            in_token,
    output logic            in_done_ok,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    input  wire logic       tx_last
);
    int sent[$];
    logic [7:0] got[$];
    initial begin
        {sof_seen, sof_corrupt, rx_valid, rx_end, rx_bad, in_token, in_done_ok} = '0;
        rx_data = 8'h5A;
    end
    task automatic sof(input bit corrupt);
        @(posedge clk);
        sof_seen    <= !corrupt;
        sof_corrupt <= corrupt;
        @(posedge clk);
        sof_seen    <= 1'h0;
        sof_corrupt <= 1'h0;
    endtask
    // random idle gaps make a slow sender; a released data line shows the inverse of its last value, so two releases in a row show a stale byte
    task automatic send(input int n, input bit bad);
        logic [8:0] b;
        sent.delete();
        @(posedge clk);
        for (int i = 0; i < n; i++) begin
            b = 9'($urandom);
            if (b[8]) begin
                rx_valid <= 1'h0;
                rx_data  <= ~rx_data;
                @(posedge clk);
            end
            rx_data  <= b[7:0];
            rx_valid <= 1'h1;
            sent.push_back(b[7:0]);
            do @(posedge clk); while (rx_ready !== 1'h1);
        end
        rx_valid <= 1'h0;
        rx_data  <= ~rx_data;
        rx_end   <= 1'h1;
        rx_bad   <= bad;
        @(posedge clk);
        rx_end   <= 1'h0;
        rx_bad   <= 1'h0;
    endtask
    task automatic fetch(input bit done);
        got.delete();
        @(posedge clk);
        in_token <= 1'h1;
        @(posedge clk);
        in_token <= 1'h0;
        for (int t = 0; t < 100; t++) begin
            @(posedge clk);
            if (tx_valid === 1'h1)
                got.push_back(tx_data);
            if (tx_valid === 1'h1 && tx_last === 1'h1)
                break;
        end
        if (done) begin
            in_done_ok <= 1'h1;
            @(posedge clk);
            in_done_ok <= 1'h0;
        end
    endtask
endmodule

// ---- uiso_pkg.sv ----
package uiso_pkg;
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } uiso_byte_t;
    typedef struct packed {
        logic data_flush;
        logic iso_err;
        logic miss_in;
        logic stall;
        logic nak;
        logic ack;
    } uiso_stat_t;
    typedef enum logic [1:0] {
        TX_IDLE = 2'h0,
        TX_SEND = 2'h1,
        TX_LAST = 2'h3
    } uiso_tx_t;
endpackage

// ---- uiso_tb.sv ----
`timescale 1ns/1ps
`include "uiso_cfg.svh"
`define CHK(nm, e, g) begin \
    check_count++; \
    if ((g) !== (e)) begin \
        bad_count++; \
        $display("ERROR %s expected %0h seen %0h", nm, e, g); \
    end \
end
module testbench;
    localparam int DEP = 8;
    logic                CLOCK, RESETN, SOF_SEEN, SOF_CORRUPT, EP_IS_IN, EP_CLEAR, RX_VALID, RX_READY;
    logic                RX_END, RX_BAD, IN_TOKEN, IN_DONE_OK, TX_VALID, TX_LAST_BYTE, TX_FORCE_STUFF_ERR;
    logic                PROC_SEL, PROC_RD, PROC_WR, ISO_FIFO_EMPTY, TX_FULL, FLAG_FLUSH, FLAG_ISO_ERR;
    logic                FLAG_MISS_IN, FLAG_STALL, FLAG_NAK, FLAG_ACK, SOF_IRQ, EP_IRQ;
    logic [7:0]          RX_DATA, TX_DATA, PROC_WDATA, PROC_RDATA;
    logic [`UISO_CW-1:0] RX_BYTE_COUNT;
    int                  bad_count, check_count, rbg[$], rfg[$], tbg[$], tfg[$];
    bit                  rbad, tdone, seen;
    uiso_ep #(.DEPTH(DEP)) dut (
        .CLOCK(CLOCK), .RESETN(RESETN), .SOF_SEEN(SOF_SEEN), .SOF_CORRUPT(SOF_CORRUPT), .EP_IS_IN(EP_IS_IN),
        .EP_CLEAR(EP_CLEAR), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .RX_READY(RX_READY), .RX_END(RX_END),
        .RX_BAD(RX_BAD), .IN_TOKEN(IN_TOKEN), .IN_DONE_OK(IN_DONE_OK), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
        .TX_LAST_BYTE(TX_LAST_BYTE), .TX_FORCE_STUFF_ERR(TX_FORCE_STUFF_ERR), .PROC_SEL(PROC_SEL),
        .PROC_RD(PROC_RD), .PROC_WR(PROC_WR), .PROC_WDATA(PROC_WDATA), .PROC_RDATA(PROC_RDATA),
        .RX_BYTE_COUNT(RX_BYTE_COUNT), .ISO_FIFO_EMPTY(ISO_FIFO_EMPTY), .TX_FULL(TX_FULL),
        .FLAG_FLUSH(FLAG_FLUSH), .FLAG_ISO_ERR(FLAG_ISO_ERR), .FLAG_MISS_IN(FLAG_MISS_IN),
        .FLAG_STALL(FLAG_STALL), .FLAG_NAK(FLAG_NAK), .FLAG_ACK(FLAG_ACK), .SOF_IRQ(SOF_IRQ), .EP_IRQ(EP_IRQ));
    uiso_host host (
        .clk(CLOCK), .sof_seen(SOF_SEEN), .sof_corrupt(SOF_CORRUPT), .rx_data(RX_DATA), .rx_valid(RX_VALID),
        .rx_ready(RX_READY), .rx_end(RX_END), .rx_bad(RX_BAD), .in_token(IN_TOKEN), .in_done_ok(IN_DONE_OK),
        .tx_data(TX_DATA), .tx_valid(TX_VALID), .tx_last(TX_LAST_BYTE));
    initial begin
        CLOCK = 1'h0;
        forever #12.5 CLOCK = ~CLOCK;
    end
    // the whole run needs a few hundred cycles; 20000 leaves ample margin
    initial begin
        #500000;
        bad_count++;
        end_sim();
    end
    task automatic end_sim;
        if (bad_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic clr;
        @(posedge CLOCK);
        EP_CLEAR <= 1'h1;
        @(posedge CLOCK);
        EP_CLEAR <= 1'h0;
        rfg.delete();
        rbg.delete();
        tfg.delete();
        tbg.delete();
    endtask
    task automatic rst;
        RESETN <= 1'h0;
        repeat (3) @(posedge CLOCK);
        RESETN <= 1'h1;
        rfg.delete();
        rbg.delete();
        tfg.delete();
        tbg.delete();
        @(posedge CLOCK);
        `CHK("reset empty", 1, ISO_FIFO_EMPTY)
        `CHK("reset flags", 0, {FLAG_FLUSH, FLAG_ISO_ERR, FLAG_MISS_IN, RX_BYTE_COUNT})
    endtask
    // model is updated before the swap, since the fifo drains during the idle cycles first
    task automatic tsof(input bit corrupt);
        int efl = 0;
        int eer = 0;
        int emi = 0;
        repeat (6) @(posedge CLOCK);
        if (EP_IS_IN) begin
            emi = (tbg.size() != 0 && !tdone);
            tbg = tfg;
            tfg.delete();
            tdone = 0;
        end else begin
            efl = (rfg.size() != 0);
            eer = rbad;
            if (rbad)
                rbg.delete();
            rfg = rbg;
            rbg.delete();
            rbad = 0;
        end
        host.sof(corrupt);
        @(posedge CLOCK);
        `CHK("sof irq", 1, SOF_IRQ)
        @(posedge CLOCK);
        `CHK("sof pulse", 0, SOF_IRQ)
        `CHK("flush", efl, FLAG_FLUSH)
        `CHK("iso err", eer, FLAG_ISO_ERR)
        `CHK("miss in", emi, FLAG_MISS_IN)
        `CHK("handshake", 0, {FLAG_STALL, FLAG_NAK, FLAG_ACK, EP_IRQ})
        if (!EP_IS_IN) begin
            `CHK("rx count", rfg.size(), RX_BYTE_COUNT)
            `CHK("rx empty", rfg.size() == 0, ISO_FIFO_EMPTY)
        end
    endtask
    task automatic out(input int n, input bit bad);
        host.send(n, bad);
        foreach (host.sent[i])
            rbg.push_back(host.sent[i]);
        rbad = rbad | bad | (rbg.size() > DEP);
    endtask
    task automatic rd(input int n);
        int e;
        PROC_SEL <= 1'h1;
        for (int i = 0; i < n; i++) begin
            @(posedge CLOCK);
            PROC_RD <= 1'h1;
            @(posedge CLOCK);
            PROC_RD <= 1'h0;
            @(posedge CLOCK);
            e = rfg.pop_front();
            `CHK("rx byte", e, PROC_RDATA)
        end
        `CHK("rx left", rfg.size(), RX_BYTE_COUNT)
        PROC_SEL <= 1'h0;
    endtask
    task automatic wr(input int n);
        logic [7:0] b;
        PROC_SEL <= 1'h1;
        @(posedge CLOCK);
        for (int i = 0; i < n; i++) begin
            b = 8'($urandom);
            PROC_WR    <= 1'h1;
            PROC_WDATA <= b;
            if (tfg.size() < DEP)
                tfg.push_back(b);
            @(posedge CLOCK);
        end
        PROC_WR  <= 1'h0;
        PROC_SEL <= 1'h0;
        repeat (2) @(posedge CLOCK);
        `CHK("tx full", tfg.size() == DEP, TX_FULL)
    endtask
    task automatic fetch(input bit done);
        host.fetch(done);
        tdone = done;
        `CHK("tx length", tbg.size(), host.got.size())
        foreach (tbg[i])
            `CHK("tx byte", tbg[i], host.got[i])
    endtask
    initial begin
        {RESETN, EP_IS_IN, EP_CLEAR, PROC_SEL, PROC_RD, PROC_WR} = '0;
        PROC_WDATA = 8'h00;
        void'($urandom(83796));
        rst();
        tsof(0);
        out(6, 0);
        tsof(0);
        rd(4);
        out(3, 1);
        tsof(1);
        out(0, 0);
        tsof(0);
        out(DEP + 2, 0);
        tsof(0);
        out(DEP, 0);
        tsof(0);
        rd(DEP);
        out(3, 0);
        clr();
        tsof(0);
        rst();
        EP_IS_IN <= 1'h1;
        wr(DEP + 2);
        tsof(0);
        fetch(1);
        wr(3);
        tsof(0);
        tsof(0);
        fetch(1);
        wr(DEP);
        tsof(0);
        fork
            host.fetch(0);
            begin
                for (int t = 0; t < 20 && TX_VALID !== 1'h1; t++)
                    @(posedge CLOCK);
                clr();
                repeat (6) begin
                    @(posedge CLOCK);
                    seen = seen | (TX_FORCE_STUFF_ERR === 1'h1);
                end
                `CHK("stuff err", 1, seen)
            end
        join
        end_sim();
    end
endmodule
